// >>> rtl/drs_top.sv
// drs_top: drive start/stop sequencer status and supervision with APB registers
//
// Functional notes
// - tripped flag stands while a latched trip exists, until it is cleared.
// - running flag is high exactly in the enabled state.
// - jogging flag is high while the drive runs in jog mode.
// - stopping flag is high while a stop is in progress.
// - contactor output closed in operation, open on trip or leaving operation.
// - switch-on-permitted flag high when a new run command would be taken.
// - run-accepted flag high after run taken, until contactor feedback arrives.
// - ready flag high when the power stage is operable.
// - reset output pulses one cycle on entering run or jog.
// - state code 0..7 from start disabled through tripped.
// - demanded-reverse output follows forward/reverse commands, not rotation.
// - healthy clears on trip and sets again once the latched trip is cleared and run is removed.
// - run request closes contactor, starts timer, ready only after feedback.
// - no feedback before the 10 s timer expires raises a contactor trip.
// - forward and reverse together are ignored and the drive stops.
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/100ps
module drs_top
  import drs_pkg::*;
#(
  parameter logic [31:0] CONT_DELAY = drs_pkg::CONT_DELAY_CYC,
  parameter logic [31:0] FAN_HOLD   = drs_pkg::FAN_HOLD_CYC
) (
  input  wire logic        MCLK,
  input  wire logic        SYS_RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        CONTACTOR_FB,
  input  wire logic        TRIP_IN,
  input  wire logic        ZERO_SPEED,
  input  wire logic        TEMP_HIGH,
  input  wire logic        LOAD_HIGH,
  output logic             CONTACTOR_OUT,
  output logic             SYS_RESET_OUT,
  output logic             DEMANDED_REVERSE_OUT,
  output logic             FAN_OUT,
  output logic             IRQ
);
  import drs_pkg::*;

  drs_state_t          state_r, state_nxt;
  logic [CTRL_W-1:0]   ctrl_r;
  logic [IRQ_W-1:0]    irq_stat_r, irq_mask_r, irq_evt;
  logic [31:0]         cont_cnt_r, fan_cnt_r;
  logic [4:0]          sync1_r, sync2_r;
  logic                jog_mode_r, healthy_r, latched_r, cont_trip_r, trip_rst;
  logic                fb, trip_src, zero_spd, heat;
  logic                run_fwd, run_rev, jog, run_cmd, permissive, cont_expired;
  logic                apb_setup, apb_done, wr_en, mapped;
  logic [31:0]         rd_val, status;

  // state code as published for each sequencer state
  function automatic logic [2:0] state_code(input drs_state_t s);
    unique case (s)
      S_START_DIS:   state_code = 3'h0;
      S_START_EN:    state_code = 3'h1;
      S_RUN_ACCEPTED_FLAG: state_code = 3'h2;
      S_READY:       state_code = 3'h3;
      S_ENABLED:     state_code = 3'h4;
      S_FSTOP:       state_code = 3'h5;
      S_TRIP_ACTIVE: state_code = 3'h6;
      S_TRIPPED:     state_code = 3'h7;
    endcase
  endfunction

  // two-stage synchronisers for the five drive status pin inputs
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
    end else begin
      sync1_r <= {LOAD_HIGH, TEMP_HIGH, ZERO_SPEED, TRIP_IN, CONTACTOR_FB};
      sync2_r <= sync1_r;
    end
  end

  assign fb       = sync2_r[0];
  assign trip_src = sync2_r[1];
  assign zero_spd = sync2_r[2];
  assign heat     = sync2_r[3] | sync2_r[4];

  // command decode
  assign run_fwd      = ctrl_r[CTRL_RUN_FWD];
  assign run_rev      = ctrl_r[CTRL_RUN_REV];
  assign jog          = ctrl_r[CTRL_JOG];
  assign run_cmd      = (run_fwd ^ run_rev) | jog;
  assign permissive   = ctrl_r[CTRL_ENABLE] & ctrl_r[CTRL_NOT_FSTOP]
                      & ctrl_r[CTRL_NOT_CSTOP] & healthy_r;
  assign cont_expired = (cont_cnt_r == 32'h0000_0000);
  assign trip_rst     = wr_en && PADDR == DRS_CTRL_OFS && PWDATA[CTRL_TRIP_RST];

  // next sequencer state, evaluated every clock
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      S_START_DIS:
        if (permissive && !run_cmd) state_nxt = S_START_EN;
      S_START_EN:
        if (!permissive) state_nxt = S_START_DIS;
        else if (run_cmd) state_nxt = S_RUN_ACCEPTED_FLAG;
      S_RUN_ACCEPTED_FLAG:
        if (!permissive || !run_cmd) state_nxt = S_START_EN;
        else if (fb) state_nxt = S_READY;
      S_READY:
        if (!permissive || !run_cmd) state_nxt = S_START_EN;
        else state_nxt = S_ENABLED;
      S_ENABLED:
        if (!ctrl_r[CTRL_NOT_FSTOP]) state_nxt = S_FSTOP;
        else if (!ctrl_r[CTRL_NOT_CSTOP] || !ctrl_r[CTRL_ENABLE]) state_nxt = S_START_DIS;
        else if (!run_cmd && zero_spd) state_nxt = S_START_EN;
      S_FSTOP:
        if (zero_spd) state_nxt = S_START_DIS;
      S_TRIP_ACTIVE:
        if (!trip_src) state_nxt = S_TRIPPED;
      S_TRIPPED:
        if (trip_rst) state_nxt = S_START_DIS;
    endcase
    if (trip_src || (state_r == S_RUN_ACCEPTED_FLAG && !fb && cont_expired))
      state_nxt = S_TRIP_ACTIVE;
  end

  // state register and jog mode captured on entry to operation
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      state_r    <= S_START_DIS;
      jog_mode_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_nxt == S_ENABLED && state_r != S_ENABLED)
        jog_mode_r <= jog && !(run_fwd ^ run_rev);
    end
  end

  // contactor delay timer, loaded on run acceptance
  always_ff @(posedge MCLK) begin
    if (SYS_RST)
      cont_cnt_r <= CONT_DELAY;
    else if (state_r != S_RUN_ACCEPTED_FLAG)
      cont_cnt_r <= CONT_DELAY;
    else if (!cont_expired)
      cont_cnt_r <= cont_cnt_r - 32'h0000_0001;
  end

  // latched trip, contactor-trip cause and healthy
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      latched_r   <= 1'b0;
      cont_trip_r <= 1'b0;
      healthy_r   <= 1'b1;
    end else begin
      if (state_nxt == S_TRIP_ACTIVE && state_r != S_TRIP_ACTIVE) begin
        latched_r   <= 1'b1;
        cont_trip_r <= !trip_src;
      end else if (state_r == S_TRIPPED && trip_rst) begin
        latched_r   <= 1'b0;
        cont_trip_r <= 1'b0;
      end
      // healthy drops on trip, returns with latched trip cleared and run removed
      if (state_nxt == S_TRIP_ACTIVE)
        healthy_r <= 1'b0;
      else if (!latched_r && !run_fwd && !run_rev && !jog)
        healthy_r <= 1'b1;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      fan_cnt_r <= 32'h0000_0000;
      FAN_OUT   <= 1'b0;
    end else begin
      if (heat)
        fan_cnt_r <= FAN_HOLD;
      else if (fan_cnt_r != 32'h0000_0000)
        fan_cnt_r <= fan_cnt_r - 32'h0000_0001;
      FAN_OUT <= heat || fan_cnt_r > 32'h0000_0001;
    end
  end

  // coil and reset outputs registered from next state so they align with the state code, reverse from the commands
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      CONTACTOR_OUT        <= 1'b0;
      SYS_RESET_OUT        <= 1'b0;
      DEMANDED_REVERSE_OUT <= 1'b0;
    end else begin
      CONTACTOR_OUT <= state_nxt inside {S_RUN_ACCEPTED_FLAG, S_READY, S_ENABLED, S_FSTOP};
      // one-cycle pulse on entry to run or jog
      SYS_RESET_OUT <= state_nxt == S_ENABLED && state_r != S_ENABLED;
      DEMANDED_REVERSE_OUT <= run_rev && !run_fwd;
    end
  end

  // status word derived from the current state in one place
  always_comb begin
    status = 32'h0000_0000;
    status[ST_CODE_LSB +: 3] = state_code(state_r);
    status[ST_TRIPPED]    = latched_r;
    status[ST_RUNNING]    = state_r == S_ENABLED;
    status[ST_JOGGING]    = state_r == S_ENABLED && jog_mode_r;
    status[ST_STOPPING]   = state_r == S_FSTOP || (state_r == S_ENABLED && !run_cmd);
    status[ST_CONTACTOR]  = CONTACTOR_OUT;
    status[ST_SW_ON_PERM] = state_r == S_START_EN;
    status[ST_RUN_ACCEPT] = state_r == S_RUN_ACCEPTED_FLAG;
    status[ST_READY]      = state_r == S_READY;
    status[ST_HEALTHY]    = healthy_r;
    status[ST_DEM_REV]    = DEMANDED_REVERSE_OUT;
    status[ST_FAN]        = FAN_OUT;
    status[ST_CONT_TRIP]  = cont_trip_r;
  end

  // APB phase decode: answer prepared in setup, taken in access
  assign apb_setup = PSEL && !PENABLE;
  assign apb_done  = PSEL && PENABLE && PREADY;
  assign wr_en     = apb_done && PWRITE && !PSLVERR;
  assign mapped    = PADDR inside {DRS_CTRL_OFS, DRS_STATUS_OFS,
                                   DRS_IRQ_STAT_OFS, DRS_IRQ_MASK_OFS};

  // read mux
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (PADDR)
      DRS_CTRL_OFS:     rd_val[CTRL_W-1:0] = ctrl_r;
      DRS_STATUS_OFS:   rd_val = status;
      DRS_IRQ_STAT_OFS: rd_val[IRQ_W-1:0] = irq_stat_r;
      DRS_IRQ_MASK_OFS: rd_val[IRQ_W-1:0] = irq_mask_r;
      default:          rd_val = 32'h0000_0000;
    endcase
  end

  // APB answer: one wait-free access phase, error on unmapped address
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else if (apb_setup) begin
      PREADY  <= 1'b1;
      PSLVERR <= !mapped;
      PRDATA  <= PWRITE ? 32'h0000_0000 : rd_val;
    end else if (apb_done) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end

  // control and mask registers
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      ctrl_r     <= CTRL_RESET;
      irq_mask_r <= IRQ_MASK_RESET;
    end else if (wr_en) begin
      if (PADDR == DRS_CTRL_OFS)
        ctrl_r <= PWDATA[CTRL_W-1:0];
      if (PADDR == DRS_IRQ_MASK_OFS)
        irq_mask_r <= PWDATA[IRQ_W-1:0];
    end
  end

  // interrupt events
  assign irq_evt[IRQ_TRIP]      = state_nxt == S_TRIP_ACTIVE && state_r != S_TRIP_ACTIVE;
  assign irq_evt[IRQ_CONT_TRIP] = irq_evt[IRQ_TRIP] && !trip_src;
  assign irq_evt[IRQ_RUN_ENTRY] = state_nxt == S_ENABLED && state_r != S_ENABLED;

  // sticky status, write one to clear, a new event wins over the clear
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      irq_stat_r <= 3'h0;
      IRQ        <= 1'b0;
    end else begin
      if (wr_en && PADDR == DRS_IRQ_STAT_OFS)
        irq_stat_r <= (irq_stat_r & ~PWDATA[IRQ_W-1:0]) | irq_evt;
      else
        irq_stat_r <= irq_stat_r | irq_evt;
      IRQ <= |(irq_stat_r & irq_mask_r);
    end
  end

endmodule // drs_top

// >>> rtl/drs_pkg.sv
// drs_pkg: constants, register map and types of the drive run sequencer
package drs_pkg;
  // register byte offsets
  localparam logic [7:0] DRS_CTRL_OFS     = 8'h00;
  localparam logic [7:0] DRS_STATUS_OFS   = 8'h04;
  localparam logic [7:0] DRS_IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] DRS_IRQ_MASK_OFS = 8'h0c;
  // control register fields
  localparam int CTRL_RUN_FWD   = 0;
  localparam int CTRL_RUN_REV   = 1;
  localparam int CTRL_JOG       = 2;
  localparam int CTRL_ENABLE    = 3;
  localparam int CTRL_NOT_FSTOP = 4;
  localparam int CTRL_NOT_CSTOP = 5;
  localparam int CTRL_TRIP_RST  = 6; // write one: clears latched trip, reads zero
  localparam int CTRL_W         = 6;
  localparam logic [5:0] CTRL_RESET = 6'h38; // enable and both stop permissives true
  // status register fields
  localparam int ST_CODE_LSB    = 0;  // three bits
  localparam int ST_TRIPPED     = 3;
  localparam int ST_RUNNING     = 4;
  localparam int ST_JOGGING     = 5;
  localparam int ST_STOPPING    = 6;
  localparam int ST_CONTACTOR   = 7;
  localparam int ST_SW_ON_PERM  = 8;
  localparam int ST_RUN_ACCEPT  = 9;
  localparam int ST_READY       = 10;
  localparam int ST_HEALTHY     = 11;
  localparam int ST_DEM_REV     = 12;
  localparam int ST_FAN         = 13;
  localparam int ST_CONT_TRIP   = 14;
  // interrupt status and mask fields
  localparam int IRQ_TRIP       = 0;
  localparam int IRQ_CONT_TRIP  = 1;
  localparam int IRQ_RUN_ENTRY  = 2;
  localparam int IRQ_W          = 3;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
  // timing
  localparam int CLK_KHZ        = 20000;
  localparam int CONT_DELAY_MS  = 10000;
  localparam int FAN_HOLD_MS    = 60000;
  localparam logic [31:0] CONT_DELAY_CYC = 32'(CONT_DELAY_MS * CLK_KHZ);
  localparam logic [31:0] FAN_HOLD_CYC   = 32'(FAN_HOLD_MS * CLK_KHZ);
  // sequencer states
  typedef enum logic [2:0] {
    S_START_DIS, S_START_EN, S_RUN_ACCEPTED_FLAG, S_READY,
    S_ENABLED, S_FSTOP, S_TRIP_ACTIVE, S_TRIPPED
  } drs_state_t;
endpackage

// >>> sim/drs_contactor_model.sv
// drs_contactor_model: external power contactor answering the coil output
`timescale 1ns/100ps
module drs_contactor_model #(
  parameter int DLY = 3
) (
  input  wire logic clk,
  input  wire logic coil,
  input  wire logic stuck,
  output logic      fb
);
  logic [7:0] cnt_r = 8'h00;
  // contacts close DLY cycles after the coil, a stuck contactor never closes
  always_ff @(posedge clk) begin
    if (!coil || stuck) begin
      cnt_r <= 8'h00;
    end else if (cnt_r < 8'(DLY)) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
  // feedback drops with the coil at once
  assign fb = coil && !stuck && (cnt_r == 8'(DLY));
endmodule // drs_contactor_model

// >>> sim/drs_assertions.sv
// drs_assertions: port-level checks of the drive run sequencer
`timescale 1ns/100ps
module drs_assertions #(
  parameter logic [31:0] CONT_DELAY = 32'h14,
  parameter logic [31:0] FAN_HOLD   = 32'h1e
) (
  input wire logic        MCLK,
  input wire logic        SYS_RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        CONTACTOR_FB,
  input wire logic        TRIP_IN,
  input wire logic        TEMP_HIGH,
  input wire logic        LOAD_HIGH,
  input wire logic        CONTACTOR_OUT,
  input wire logic        SYS_RESET_OUT,
  input wire logic        FAN_OUT
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  logic [31:0] open_cnt_r;
  logic [31:0] cool_cnt_r;
  sequence setup_s; PSEL && !PENABLE; endsequence
  sequence done_s; PSEL && PENABLE && PREADY; endsequence
  // cycles with coil closed and no feedback, cycles with no heat
  always_ff @(posedge MCLK) begin
    open_cnt_r <= (SYS_RST || !CONTACTOR_OUT || CONTACTOR_FB) ? 32'h0 : open_cnt_r + 32'h1;
    cool_cnt_r <= (SYS_RST || TEMP_HIGH || LOAD_HIGH) ? 32'h0 : cool_cnt_r + 32'h1;
  end
  apb_zero_wait_a:
    assert property (setup_s |=> done_s) else $error("no ready after setup");
  err_read_zero_a:
    assert property (done_s and PSLVERR && !PWRITE |-> PRDATA == 32'h0) else $error("err data");
  unmapped_err_a:
    assert property (done_s and PADDR > 8'h0c |-> PSLVERR) else $error("unmapped not refused");
  pulse_single_a:
    assert property (SYS_RESET_OUT |=> !SYS_RESET_OUT) else $error("reset pulse too long");
  pulse_after_fb_a:
    assert property (SYS_RESET_OUT |-> CONTACTOR_OUT && $past(CONTACTOR_FB, 2)) else $error("run without fb");
  trip_opens_a:
    assert property (TRIP_IN [*4] |-> !CONTACTOR_OUT) else $error("coil held on trip");
  fb_timeout_a:
    assert property (open_cnt_r <= CONT_DELAY + 32'h4) else $error("no contactor timeout");
  fan_on_a:
    assert property ((TEMP_HIGH || LOAD_HIGH) [*4] |-> FAN_OUT) else $error("fan not requested");
  fan_off_a:
    assert property (cool_cnt_r > FAN_HOLD + 32'h8 |-> !FAN_OUT) else $error("fan held too long");
endmodule // drs_assertions

bind drs_top drs_assertions #(.CONT_DELAY(CONT_DELAY), .FAN_HOLD(FAN_HOLD)) drs_assertions_i (
  .MCLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PRDATA, .PREADY, .PSLVERR, .CONTACTOR_FB,
  .TRIP_IN, .TEMP_HIGH, .LOAD_HIGH, .CONTACTOR_OUT, .SYS_RESET_OUT, .FAN_OUT);

// >>> sim/drs_top_tb_top.sv
// drs_top_tb_top: self-checking bench of the drive run sequencer
`timescale 1ns/100ps
module drs_top_tb_top;
  import drs_pkg::*;
  localparam int CD = 20;
  localparam int FH = 30;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d, m, x; logic e;} drs_row_t;
  logic MCLK = 0, SYS_RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, erv;
  logic TRIP_IN = 0, ZERO_SPEED = 0, TEMP_HIGH = 0, LOAD_HIGH = 0, stuck = 0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, rdv;
  logic PREADY, PSLVERR, CONTACTOR_FB, CONTACTOR_OUT, SYS_RESET_OUT, DEMANDED_REVERSE_OUT;
  logic FAN_OUT, IRQ;
  int   fails = 0, n_tests = 0;
  drs_row_t rows[8] = '{
    '{'0, DRS_CTRL_OFS, '0, 32'hff, 32'h38, '0},
    '{'0, DRS_STATUS_OFS, '0, 32'hfffffbff, 32'h901, '0},
    '{'0, DRS_IRQ_STAT_OFS, '0, '1, '0, '0},
    '{'0, DRS_IRQ_MASK_OFS, '0, '1, '0, '0},
    '{'1, 8'h10, 32'h5, '0, '0, '1},
    '{'0, 8'h10, '0, '1, '0, '1},
    '{'1, DRS_IRQ_MASK_OFS, 32'h7, '0, '0, '0},
    '{'0, DRS_IRQ_MASK_OFS, '0, '1, 32'h7, '0}};
  drs_top #(.CONT_DELAY(32'(CD)), .FAN_HOLD(32'(FH))) drs_top_i (.MCLK, .SYS_RST, .PSEL,
    .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .CONTACTOR_FB, .TRIP_IN,
    .ZERO_SPEED, .TEMP_HIGH, .LOAD_HIGH, .CONTACTOR_OUT, .SYS_RESET_OUT, .DEMANDED_REVERSE_OUT,
    .FAN_OUT, .IRQ);
  drs_contactor_model drs_contactor_model_i (.clk(MCLK), .coil(CONTACTOR_OUT), .stuck(stuck),
    .fb(CONTACTOR_FB));
  // 20 MHz clock
  always #25 MCLK = ~MCLK;
  task automatic end_sim();
    if (fails == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] s, logic [31:0] x);
    n_tests++;
    if (s !== x) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic cb(string n, logic s, logic x);
    chk(n, {31'h0, s}, {31'h0, x});
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge MCLK);
  endtask
  // one apb transfer, held until ready, then one idle edge
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int i;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge MCLK);
      if (PREADY === 1'b1) break;
    end
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (i == 20) begin
      fails++;
      end_sim();
    end
    @(posedge MCLK);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    apb(1'b1, a, d, rdv, erv);
  endtask
  task automatic rdc(string n, logic [7:0] a, logic [31:0] m, logic [31:0] x);
    apb(1'b0, a, 32'h0, rdv, erv);
    chk(n, rdv & m, x);
  endtask
  // wait for the one-cycle run entry pulse
  task automatic pulse();
    int i;
    for (i = 0; i < 200 && SYS_RESET_OUT !== 1'b1; i++) @(posedge MCLK);
    if (i == 200) begin
      fails++;
      end_sim();
    end
  endtask
  // remove run and let the motor reach standstill
  task automatic stop_z();
    wr(DRS_CTRL_OFS, 32'h38);
    ZERO_SPEED <= 1'b1;
    cyc(6);
    ZERO_SPEED <= 1'b0;
    cyc(2);
    rdc("idle state", DRS_STATUS_OFS, 32'hff, 32'h1);
  endtask
  // main sequence: register table, then run, stop, jog, trips and fan
  initial begin
    cyc(5);
    SYS_RST <= 1'b0;
    cyc(4);
    foreach (rows[k]) begin
      apb(rows[k].w, rows[k].a, rows[k].d, rdv, erv);
      chk("rdata", rdv & rows[k].m, rows[k].x);
      cb("slverr", erv, rows[k].e);
    end
    wr(DRS_CTRL_OFS, 32'h39);
    pulse();
    cb("coil", CONTACTOR_OUT, 1'b1);
    cyc(1);
    cb("reset pulse", SYS_RESET_OUT, 1'b0);
    rdc("run state", DRS_STATUS_OFS, 32'h40ff, 32'h94);
    cb("irq", IRQ, 1'b1);
    wr(DRS_IRQ_STAT_OFS, 32'h4);
    cyc(2);
    cb("irq", IRQ, 1'b0);
    wr(DRS_IRQ_MASK_OFS, 32'h0);
    wr(DRS_CTRL_OFS, 32'h3a);
    cyc(2);
    cb("reverse", DEMANDED_REVERSE_OUT, 1'b1);
    wr(DRS_CTRL_OFS, 32'h3b);
    cyc(2);
    cb("reverse", DEMANDED_REVERSE_OUT, 1'b0);
    rdc("stopping", DRS_STATUS_OFS, 32'h50, 32'h50);
    stop_z();
    wr(DRS_CTRL_OFS, 32'h3c);
    pulse();
    cyc(1);
    rdc("jogging", DRS_STATUS_OFS, 32'h20, 32'h20);
    stop_z();
    wr(DRS_CTRL_OFS, 32'h39);
    pulse();
    TRIP_IN <= 1'b1;
    cyc(5);
    cb("coil", CONTACTOR_OUT, 1'b0);
    rdc("trip active", DRS_STATUS_OFS, 32'h80f, 32'he);
    TRIP_IN <= 1'b0;
    cyc(5);
    rdc("tripped", DRS_STATUS_OFS, 32'hf, 32'hf);
    wr(DRS_CTRL_OFS, 32'h38);
    wr(DRS_CTRL_OFS, 32'h78);
    cyc(4);
    rdc("healthy", DRS_STATUS_OFS, 32'h80f, 32'h801);
    stuck <= 1'b1;
    wr(DRS_CTRL_OFS, 32'h39);
    rdc("run accepted", DRS_STATUS_OFS, 32'h28f, 32'h282);
    cyc(CD + 10);
    cb("coil", CONTACTOR_OUT, 1'b0);
    rdc("fb trip", DRS_STATUS_OFS, 32'h400f, 32'h400f);
    cb("irq", IRQ, 1'b0);
    rdc("irq stat", DRS_IRQ_STAT_OFS, 32'h2, 32'h2);
    wr(DRS_IRQ_MASK_OFS, 32'h2);
    cyc(2);
    cb("irq", IRQ, 1'b1);
    wr(DRS_IRQ_STAT_OFS, 32'h7);
    cyc(2);
    cb("irq", IRQ, 1'b0);
    stuck <= 1'b0;
    wr(DRS_CTRL_OFS, 32'h38);
    wr(DRS_CTRL_OFS, 32'h78);
    TEMP_HIGH <= 1'b1;
    cyc(6);
    cb("fan", FAN_OUT, 1'b1);
    LOAD_HIGH <= 1'b1;
    TEMP_HIGH <= 1'b0;
    cyc(6);
    LOAD_HIGH <= 1'b0;
    cyc(FH - 10);
    cb("fan", FAN_OUT, 1'b1);
    cyc(30);
    cb("fan", FAN_OUT, 1'b0);
    // mid-run reset: outputs and registers return to reset values
    wr(DRS_CTRL_OFS, 32'h39);
    pulse();
    SYS_RST <= 1'b1;
    cyc(5);
    SYS_RST <= 1'b0;
    cyc(4);
    cb("coil", CONTACTOR_OUT, 1'b0);
    cb("reset pulse", SYS_RESET_OUT, 1'b0);
    rdc("ctrl reset", DRS_CTRL_OFS, 32'hff, 32'h38);
    rdc("reset state", DRS_STATUS_OFS, 32'hfffffbff, 32'h901);
    rdc("mask reset", DRS_IRQ_MASK_OFS, 32'h7, 32'h0);
    end_sim();
  end
endmodule // drs_top_tb_top
